// ### shared/adccs_defines.vh
// register map, field positions and reset values of the channel-select converter block
`ifndef ADCCS_DEFINES_VH
`define ADCCS_DEFINES_VH

`define ADCCS_ADDR_W        6
`define ADCCS_OFF_CTRL      6'h00
`define ADCCS_OFF_STATUS    6'h04
`define ADCCS_OFF_MASK      6'h08
`define ADCCS_OFF_RESULT    6'h0c
`define ADCCS_OFF_CHAN      6'h10

`define ADCCS_CTRL_ONDEMAND 0
`define ADCCS_CTRL_SLEEP    1
`define ADCCS_CTRL_RST      2'h0

`define ADCCS_EV_DONE       0
`define ADCCS_EV_OVR        1
`define ADCCS_EV_W          2
`define ADCCS_EV_RST        2'h0

`define ADCCS_RES_W         10
`define ADCCS_HI_W          4
`define ADCCS_LO_W          6
`define ADCCS_IN_W          11
`define ADCCS_RES_OVR_BIT   10
`define ADCCS_FULL_SCALE    10'h3ff

`define ADCCS_RESP_OKAY     2'h0
`define ADCCS_RESP_SLVERR   2'h2

`endif

// ### logic/adccs_top.v
// channel-select, two-step result path and register slave of the sampling converter
`timescale 1ns/1ps
`include "adccs_defines.vh"

// Behaviour
// - strobe low routes input addressed by two select bits; strobe high keeps selection
// - sleep input high freezes all result outputs until released
// - result is a 10-bit word, bit 9 most significant, bit 0 least
// - first stage resolves upper 4 bits, second stage the lower 6 bits
// - supports on-demand single pulses and free-running pipelined conversions
// - floating strobe and select lines read low, so input 1 stays selected
module adccs_top (
    input  wire        aclk,            // system clock, 100 MHz
    input  wire        aresetn,         // synchronous reset, active low
    input  wire [5:0]  s_axi_awaddr,    // write address
    input  wire        s_axi_awvalid,   // write address valid
    output reg         s_axi_awready,   // write address ready
    input  wire [31:0] s_axi_wdata,     // write data
    input  wire [3:0]  s_axi_wstrb,     // write byte strobes
    input  wire        s_axi_wvalid,    // write data valid
    output reg         s_axi_wready,    // write data ready
    output reg  [1:0]  s_axi_bresp,     // write response
    output reg         s_axi_bvalid,    // write response valid
    input  wire        s_axi_bready,    // write response ready
    input  wire [5:0]  s_axi_araddr,    // read address
    input  wire        s_axi_arvalid,   // read address valid
    output reg         s_axi_arready,   // read address ready
    output reg  [31:0] s_axi_rdata,     // read data
    output reg  [1:0]  s_axi_rresp,     // read response
    output reg         s_axi_rvalid,    // read data valid
    input  wire        s_axi_rready,    // read data ready
    input  wire        chan_wr_n,       // channel write strobe pin, active low
    input  wire        chan_sel_hi,     // channel address bit 1 pin
    input  wire        chan_sel_lo,     // channel address bit 0 pin
    input  wire        conv_clk,        // conversion clock pin from controller
    input  wire        sleep_in,        // power-down pin, active high
    input  wire [10:0] input_ch1,       // sampled level of input 1, above 1023 is over range
    input  wire [10:0] input_ch2,       // sampled level of input 2
    input  wire [10:0] input_ch3,       // sampled level of input 3
    input  wire [10:0] input_ch4,       // sampled level of input 4
    output reg  [9:0]  result_word,     // result, bit 9 msb, bit 0 lsb
    output reg         over_range_out,  // over-range flag of the present result
    output reg         irq              // level interrupt
);

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    // byte-lane merge of a write into a narrow register
    function [1:0] lane0_merge;
        input [1:0]  old_v;
        input [31:0] wdat;
        input [3:0]  strb;
        begin
            lane0_merge = strb[0] ? wdat[1:0] : old_v;
        end
    endfunction

    // clamp an input level to full scale
    function [9:0] clamp_code;
        input [10:0] lvl;
        begin
            clamp_code = lvl[10] ? `ADCCS_FULL_SCALE : lvl[9:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    reg         ctl_s1_q;                // first stage: sleep pin
    reg         ctl_s2_q;
    reg  [2:0]  sel_s1_q;                // first stage: strobe low, hi, lo
    reg  [2:0]  sel_s2_q;
    reg         cclk_s1_q;
    reg         cclk_s2_q;
    reg         cclk_s3_q;               // edge-detect history
    reg  [10:0] in_s1_q [0:3];
    reg  [10:0] in_s2_q [0:3];
    wire [10:0] in_pin  [0:3];

    assign in_pin[0] = input_ch1;
    assign in_pin[1] = input_ch2;
    assign in_pin[2] = input_ch3;
    assign in_pin[3] = input_ch4;

    // two flops on every analog-side input word
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_in_sync
            always @(posedge aclk) begin
                in_s1_q[gi] <= in_pin[gi];
                in_s2_q[gi] <= in_s1_q[gi];
            end
        end
    endgenerate

    // control pins; a floating pin reads as 0 behind its pad pull-down
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctl_s1_q  <= 1'b0;
            ctl_s2_q  <= 1'b0;
            sel_s1_q  <= 3'h0;
            sel_s2_q  <= 3'h0;
            cclk_s1_q <= 1'b0;
            cclk_s2_q <= 1'b0;
            cclk_s3_q <= 1'b0;
        end else begin
            ctl_s1_q  <= sleep_in;
            ctl_s2_q  <= ctl_s1_q;
            sel_s1_q  <= {~chan_wr_n, chan_sel_hi, chan_sel_lo};
            sel_s2_q  <= sel_s1_q;
            cclk_s1_q <= conv_clk;
            cclk_s2_q <= cclk_s1_q;
            cclk_s3_q <= cclk_s2_q;
        end
    end

    wire cclk_rise = cclk_s2_q & ~cclk_s3_q;
    wire cclk_fall = ~cclk_s2_q & cclk_s3_q;

    ////////////////////////////////////////////////////////////////////////////////
    // channel selection and two-step conversion

    reg  [1:0] ctrl_q;
    reg  [1:0] chan_q;
    reg  [3:0] coarse_q;                 // first-stage upper bits
    reg  [5:0] fine_q;                   // held lower bits for second stage
    reg        ovr1_q;
    reg        stg1_full_q;
    reg  [1:0] ev_set;

    wire ondemand  = ctrl_q[`ADCCS_CTRL_ONDEMAND];
    wire sleeping  = ctl_s2_q | ctrl_q[`ADCCS_CTRL_SLEEP];
    // second stage: next clock rise when pipelined, same pulse's fall when on demand
    wire stg2_fire = stg1_full_q & (ondemand ? cclk_fall : cclk_rise);
    wire [9:0] samp_code = clamp_code(in_s2_q[chan_q]);

    // selection latch: follows the address only while the strobe is low
    always @(posedge aclk) begin
        if (!aresetn) begin
            chan_q <= 2'h0;
        end else if (sel_s2_q[2]) begin
            chan_q <= sel_s2_q[1:0];
        end
    end

    // first stage on each rise, second stage into the frozen-able outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            coarse_q       <= 4'h0;
            fine_q         <= 6'h00;
            ovr1_q         <= 1'b0;
            stg1_full_q    <= 1'b0;
            result_word    <= 10'h000;
            over_range_out <= 1'b0;
            ev_set         <= 2'h0;
        end else begin
            ev_set <= 2'h0;
            if (stg2_fire && !sleeping) begin
                result_word    <= {coarse_q, fine_q};
                over_range_out <= ovr1_q;
                ev_set         <= {ovr1_q, 1'b1};
            end
            if (stg2_fire) begin
                stg1_full_q <= 1'b0;
            end
            if (cclk_rise) begin
                coarse_q    <= samp_code[9:6];
                fine_q      <= samp_code[5:0];
                ovr1_q      <= in_s2_q[chan_q][10];
                stg1_full_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register slave and interrupt

    reg  [5:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         aw_have_q;
    reg         w_have_q;
    reg  [1:0]  sts_q;
    reg  [1:0]  mask_q;
    reg  [1:0]  sts_d;
    reg  [1:0]  sts_clr;
    reg  [31:0] rd_word;
    reg  [1:0]  rd_resp;

    wire wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;

    // write-one-to-clear with hardware set winning
    always @* begin
        sts_clr = 2'h0;
        if (wr_go && awaddr_q == `ADCCS_OFF_STATUS) begin
            sts_clr = lane0_merge(2'h0, wdata_q, wstrb_q);
        end
        sts_d = (sts_q & ~sts_clr) | ev_set;
    end

    // read decode
    always @* begin
        rd_word = 32'h0000_0000;
        rd_resp = `ADCCS_RESP_OKAY;
        case (s_axi_araddr)
            `ADCCS_OFF_CTRL:   rd_word[1:0] = ctrl_q;
            `ADCCS_OFF_STATUS: rd_word[1:0] = sts_q;
            `ADCCS_OFF_MASK:   rd_word[1:0] = mask_q;
            `ADCCS_OFF_RESULT: rd_word[10:0] = {over_range_out, result_word};
            `ADCCS_OFF_CHAN:   rd_word[1:0] = chan_q;
            default:           rd_resp = `ADCCS_RESP_SLVERR;
        endcase
    end

    // write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ADCCS_RESP_OKAY;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= 6'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            ctrl_q        <= `ADCCS_CTRL_RST;
            mask_q        <= `ADCCS_EV_RST;
            sts_q         <= `ADCCS_EV_RST;
            irq           <= 1'b0;
        end else begin
            sts_q <= sts_d;
            irq   <= |(sts_d & mask_q);
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q      <= s_axi_awaddr;
                aw_have_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                w_have_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `ADCCS_RESP_OKAY;
                case (awaddr_q)
                    `ADCCS_OFF_CTRL:   ctrl_q <= lane0_merge(ctrl_q, wdata_q, wstrb_q);
                    `ADCCS_OFF_MASK:   mask_q <= lane0_merge(mask_q, wdata_q, wstrb_q);
                    `ADCCS_OFF_STATUS: ;
                    `ADCCS_OFF_RESULT: ;
                    `ADCCS_OFF_CHAN:   ;
                    default:           s_axi_bresp <= `ADCCS_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel: one outstanding read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `ADCCS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // adccs_top

// ### verif/adccs_chk.sv
// port assertions of the converter channel-select block
`timescale 1ns/1ps
`include "adccs_defines.vh"
module adccs_chk (
    input wire       aclk,           // clock
    input wire       aresetn,        // reset
    input wire       s_axi_awvalid,  // aw valid
    input wire       s_axi_awready,  // aw ready
    input wire       s_axi_wvalid,   // w valid
    input wire       s_axi_wready,   // w ready
    input wire       s_axi_bvalid,   // b valid
    input wire       s_axi_bready,   // b ready
    input wire       s_axi_arvalid,  // ar valid
    input wire       s_axi_arready,  // ar ready
    input wire       s_axi_rvalid,   // r valid
    input wire       conv_clk,       // conversion clock
    input wire       sleep_in,       // power-down
    input wire [9:0] result_word,    // result
    input wire       over_range_out  // over range
);
    reg       conv_q;  // conv clock one cycle back
    reg [3:0] idle_q;  // cycles since conv clock moved
    // result may only move shortly after a conv clock edge
    always @(posedge aclk) begin
        conv_q <= conv_clk;
        if (!aresetn) idle_q <= 4'hf;
        else if (conv_clk != conv_q) idle_q <= 4'h0;
        else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    property p_sleep; sleep_in [*4] |=> $stable(result_word) && $stable(over_range_out); endproperty
    a_sleep: assert property (p_sleep) else $error("result moved asleep");
    property p_sat; over_range_out |-> result_word == `ADCCS_FULL_SCALE; endproperty
    a_sat: assert property (p_sat) else $error("over range not saturated");
    property p_cause; $changed(result_word) |-> idle_q <= 4'h8; endproperty
    a_cause: assert property (p_cause) else $error("result moved idle");
    property p_wlat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid; endproperty
    a_wlat: assert property (p_wlat) else $error("write answer late");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_arblk: assert property (p_arblk) else $error("read taken while busy");
    property p_awblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_awblk: assert property (p_awblk) else $error("write taken while busy");
    property p_bone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bone: assert property (p_bone) else $error("write answer repeated");
    c_ovr: cover property ($rose(over_range_out));
    c_sleep: cover property (sleep_in [*4]);
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // adccs_chk
bind adccs_top adccs_chk u_chk (.*);

// ### verif/adccs_ctrl_model.sv
// controller model driving conversion clock and channel pins
`timescale 1ns/1ps
module adccs_ctrl_model (
    input  wire aclk,        // bench clock
    output reg  conv_clk,    // conversion clock
    output reg  chan_wr_n,   // channel strobe
    output reg  chan_sel_hi, // address bit 1
    output reg  chan_sel_lo  // address bit 0
);
    // pins undriven at start, pull-downs read low
    initial begin
        conv_clk <= 1'b0;
        chan_wr_n <= 1'b0;
        chan_sel_hi <= 1'b0;
        chan_sel_lo <= 1'b0;
    end
    // address, strobe low, strobe high, then address released
    task sel(input [1:0] ch);
        @(posedge aclk);
        {chan_sel_hi, chan_sel_lo} <= ch;
        @(posedge aclk);
        chan_wr_n <= 1'b0;
        repeat (6) @(posedge aclk);
        chan_wr_n <= 1'b1;
        repeat (4) @(posedge aclk);
        {chan_sel_hi, chan_sel_lo} <= 2'h0;
    endtask
    // one 1 us period, 500 ns high then 500 ns low, one sample per period
    task pulse;
        @(posedge aclk);
        conv_clk <= 1'b1;
        repeat (50) @(posedge aclk);
        conv_clk <= 1'b0;
        repeat (50) @(posedge aclk);
    endtask
endmodule // adccs_ctrl_model

// ### verif/adc_channel_select_output_tb_top.sv
// self-checking bench of the converter channel-select block
`timescale 1ns/1ps
`include "adccs_defines.vh"
module adc_channel_select_output_tb_top;
    reg         aclk, aresetn, sleep_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready;
    reg  [5:0]  s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata;
    reg  [10:0] lvl [0:3];
    wire [3:0]  s_axi_wstrb = 4'hf;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        conv_clk, chan_wr_n, chan_sel_hi, chan_sel_lo, over_range_out, irq;
    wire [9:0]  result_word;
    wire [10:0] input_ch1 = lvl[0];
    wire [10:0] input_ch2 = lvl[1];
    wire [10:0] input_ch3 = lvl[2];
    wire [10:0] input_ch4 = lvl[3];
    int         n_errors = 0;
    int         check_count = 0;
    int         cyc = 0;
    adccs_top dut (.*);
    adccs_ctrl_model ctl (.*);
    ////////////////////////////////////////////////////////////
    task give_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task axw(input [5:0] a, input [31:0] d, input [1:0] r = `ADCCS_RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk("bresp", r, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask
    task axr(input [5:0] a, input [31:0] e, input [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk("rresp", r, s_axi_rresp);
        if (r == `ADCCS_RESP_OKAY) chk("rdata", e, s_axi_rdata);
        s_axi_rready <= 1'b0;
    endtask
    // saturating expectation of the result pins
    task res(input [10:0] v);
        chk("result_word", v[10] ? `ADCCS_FULL_SCALE : v[9:0], result_word);
        chk("over_range_out", v[10], over_range_out);
    endtask
    ////////////////////////////////////////////////////////////
    task t_regs;
        axw(6'h14, 32'h3, `ADCCS_RESP_SLVERR);
        axr(`ADCCS_OFF_CTRL, 32'h0, `ADCCS_RESP_OKAY);
        axr(`ADCCS_OFF_STATUS, 32'h0, `ADCCS_RESP_OKAY);
        axr(`ADCCS_OFF_MASK, 32'h0, `ADCCS_RESP_OKAY);
        axr(`ADCCS_OFF_CHAN, 32'h0, `ADCCS_RESP_OKAY);
        axr(6'h14, 32'h0, `ADCCS_RESP_SLVERR);
    endtask
    task t_float;
        ctl.pulse;
        ctl.pulse;
        res(lvl[0]);
    endtask
    task t_chan;
        for (int ch = 0; ch < 4; ch++) begin
            ctl.sel(ch[1:0]);
            axr(`ADCCS_OFF_CHAN, ch, `ADCCS_RESP_OKAY);
            ctl.pulse;
            ctl.pulse;
            res(lvl[ch]);
        end
    endtask
    task t_ovr;
        lvl[3] <= 11'h500;
        ctl.pulse;
        ctl.pulse;
        res(11'h500);
        chk("irq", 1'b0, irq);
        axr(`ADCCS_OFF_STATUS, 32'h3, `ADCCS_RESP_OKAY);
        axw(`ADCCS_OFF_MASK, 32'h3);
        repeat (2) @(posedge aclk);
        chk("irq", 1'b1, irq);
        axw(`ADCCS_OFF_STATUS, 32'h3);
        repeat (2) @(posedge aclk);
        chk("irq", 1'b0, irq);
    endtask
    task t_sleep;
        sleep_in <= 1'b1;
        lvl[3] <= 11'h0f0;
        ctl.pulse;
        ctl.pulse;
        res(11'h500);
        sleep_in <= 1'b0;
        ctl.pulse;
        ctl.pulse;
        res(11'h0f0);
    endtask
    task t_demand;
        axw(`ADCCS_OFF_CTRL, 32'h1);
        lvl[3] <= 11'h2c3;
        ctl.pulse;
        res(11'h2c3);
        // soft sleep freezes the on-demand result, waking resumes it
        axw(`ADCCS_OFF_CTRL, 32'h3);
        axr(`ADCCS_OFF_CTRL, 32'h3, `ADCCS_RESP_OKAY);
        lvl[3] <= 11'h011;
        ctl.pulse;
        res(11'h2c3);
        axw(`ADCCS_OFF_CTRL, 32'h1);
        ctl.pulse;
        res(11'h011);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            give_verdict;
        end
    end
    initial begin
        {aresetn, sleep_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 14'h0;
        s_axi_wdata = 32'h0;
        lvl[0] <= 11'h155;
        lvl[1] <= 11'h2aa;
        lvl[2] <= 11'h3c0;
        lvl[3] <= 11'h03f;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        t_regs;
        t_float;
        t_chan;
        t_ovr;
        t_sleep;
        t_demand;
        give_verdict;
    end
endmodule // adc_channel_select_output_tb_top
